// ### srb_defs.svh
`ifndef SRB_DEFS_SVH
`define SRB_DEFS_SVH

`define SRB_WORD_W 16
`define SRB_DATA_W 12
`define SRB_CNT_W 5
`define SRB_FRAME_BITS 5'h10
`define SRB_CNT_MAX 5'h1f

`define SRB_CMD_READ 4'h0
`define SRB_CMD_CFG_LAST 4'he
`define SRB_CMD_CHECK 4'hf

`define SRB_ADDR_STATUS 4'h0
`define SRB_ADDR_MODE 4'h5
`define SRB_ADDR_DRV 4'h7
`define SRB_ADDR_STB_V 4'hb
`define SRB_ADDR_STB_T 4'hc
`define SRB_ADDR_FAULT_OP 4'hd
`define SRB_ADDR_PWM 4'he
`define SRB_ADDR_REV 4'hf

`define SRB_CHECK_WORD 16'h0d0a
`define SRB_RESET_RESP 16'h8000
`define SRB_DATA_RESET 12'h000

`define SRB_MODE_IGN_HI 11
`define SRB_MODE_IGN_LO 8
`define SRB_MODE_V10_BIT 7
`define SRB_DRV_GP_HI 7
`define SRB_DRV_GP_LO 4
`define SRB_FOP_GAP_MASK 12'hf0f
`define SRB_REV_PAD 2'h0
`define SRB_SYNC_IDLE 3'h2

`endif

// ### srb_pkg.sv
`default_nettype none
package srb_pkg;
    typedef logic [15:0] srb_word_t;
    typedef logic [11:0] srb_data_t;
    typedef enum logic [1:0] {
        SRB_KIND_STATUS,
        SRB_KIND_REG,
        SRB_KIND_CHECK
    } srb_kind_e;
endpackage : srb_pkg
`default_nettype wire

// ### srb_sync.sv
`default_nettype none
module srb_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule : srb_sync
`default_nettype wire

// ### srb_readback.sv
`include "srb_defs.svh"
`default_nettype none
// Notes on behaviour
// - Check command is answered next frame by fixed signature word 0x0d0a.
// - Read-back words carry reset, range, overvoltage and low-voltage header.
// - A command outside the valid set raises the range flag in next word.
// - Supply flag of all-status word is overvoltage or low voltage.
// - No-max-current flag: current faults while ten-volt drivers are off.
// - Address 0xb returns four threshold fields, channel 3 highest.
// - Address 0xc returns four timer fields, channel 3 highest.
// - Address 0xd returns retry choice in top nibble, shutdown choice low.
// - Address 0xe returns only the last programmed pulse-width settings.
// - Address 0xf gives revision in bits 11-8, calibration flags in 5, 4.
// - Revision word bit 1 is trim parity error, bit 0 trim lockout.
// - Driver on/off bits show commanded register state, not output pins.
// - Ignition-mode channels never show in commanded on/off bits.
// - Write and status-read commands answer with the all-status word.
module srb_readback #(
    parameter logic [3:0] REVISION_IDENTIFIER = 4'h1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    output logic spi_so,
    output logic spi_so_oe,
    input wire logic [3:0] ign_fault,
    input wire logic [3:0] gp_fault,
    input wire logic [3:0] out_fault,
    input wire logic overvoltage,
    input wire logic low_voltage,
    input wire logic maximum_current_input,
    input wire logic nominal_current_input,
    input wire logic calibration_high_flag,
    input wire logic calibration_low_flag,
    input wire logic trim_parity_error,
    input wire logic trim_locked_out
);
    // The revision value above is arbitrary.
    logic [2:0] pins_s;
    logic sclk_prev_ff;
    logic cs_prev_ff;
    logic [15:0] rx_ff;
    logic [15:0] tx_ff;
    logic [4:0] cnt_ff;
    logic rst_flag_ff;
    srb_pkg::srb_word_t resp_ff;
    srb_pkg::srb_data_t regs_ff [0:15];

    // The flops reset to the idle pin levels; otherwise the select line
    // would show a false fall and rise just after reset.
    srb_sync #(
        .W(3),
        .RST_VAL(`SRB_SYNC_IDLE)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({spi_sclk, spi_cs_n, spi_si}),
        .sync_out(pins_s)
    );

    wire sclk_s = pins_s[2];
    wire cs_s = pins_s[1];
    wire si_s = pins_s[0];
    wire sclk_rise = sclk_s & ~sclk_prev_ff & ~cs_s;
    wire sclk_fall = ~sclk_s & sclk_prev_ff & ~cs_s;
    wire cs_fall = ~cs_s & cs_prev_ff;
    wire frame_end = cs_s & ~cs_prev_ff;

    wire [3:0] cmd = rx_ff[15:12];
    wire [3:0] addr = rx_ff[3:0];
    wire good_len = (cnt_ff == `SRB_FRAME_BITS);
    wire bad_read = (cmd == `SRB_CMD_READ) && (rx_ff[11:4] != 8'h00);
    wire cmd_bad = !good_len || bad_read;
    wire cfg_write = good_len && (cmd != `SRB_CMD_READ)
        && (cmd <= `SRB_CMD_CFG_LAST);

    wire [3:0] ign_mode = regs_ff[`SRB_ADDR_MODE]
        [`SRB_MODE_IGN_HI:`SRB_MODE_IGN_LO];
    wire v10_en = regs_ff[`SRB_ADDR_MODE][`SRB_MODE_V10_BIT];
    wire [3:0] gp_cmd = regs_ff[`SRB_ADDR_DRV]
        [`SRB_DRV_GP_HI:`SRB_DRV_GP_LO];
    // Ignition channels follow the parallel pins, so their bits are masked.
    wire [3:0] gp_cmd_shown = gp_cmd & ~ign_mode;
    wire supply_out_of_range_flag = overvoltage | low_voltage;
    // Channels in ignition mode count as off; only the register is consulted.
    wire no_maxcurrent_fault_flag = v10_en
        & (maximum_current_input | nominal_current_input)
        & ((gp_cmd_shown) == 4'h0);

    wire srb_pkg::srb_kind_e kind =
        (good_len && cmd == `SRB_CMD_CHECK) ? srb_pkg::SRB_KIND_CHECK :
        (good_len && cmd == `SRB_CMD_READ && !bad_read
            && addr != `SRB_ADDR_STATUS) ? srb_pkg::SRB_KIND_REG :
        srb_pkg::SRB_KIND_STATUS;

    function automatic srb_pkg::srb_word_t with_header(
        input logic rflag,
        input logic command_out_of_range_flag,
        input srb_pkg::srb_data_t data
    );
        with_header = {rflag, command_out_of_range_flag, overvoltage, low_voltage, data};
    endfunction : with_header

    wire srb_pkg::srb_data_t rev_data = {REVISION_IDENTIFIER, `SRB_REV_PAD,
        calibration_high_flag, calibration_low_flag, `SRB_REV_PAD,
        trim_parity_error, trim_locked_out};
    wire srb_pkg::srb_data_t drv_data = {regs_ff[`SRB_ADDR_DRV][11:8],
        gp_cmd_shown, regs_ff[`SRB_ADDR_DRV][3:0]};
    wire srb_pkg::srb_data_t reg_data =
        (addr == `SRB_ADDR_REV) ? rev_data :
        (addr == `SRB_ADDR_DRV) ? drv_data :
        (addr == `SRB_ADDR_FAULT_OP) ?
            (regs_ff[addr] & `SRB_FOP_GAP_MASK) :
        regs_ff[addr];
    wire srb_pkg::srb_word_t status_word = {rst_flag_ff, cmd_bad,
        supply_out_of_range_flag, no_maxcurrent_fault_flag,
        ign_fault, gp_fault, out_fault};
    wire srb_pkg::srb_word_t nxt_resp =
        (kind == srb_pkg::SRB_KIND_CHECK) ? `SRB_CHECK_WORD :
        (kind == srb_pkg::SRB_KIND_REG) ?
            with_header(rst_flag_ff, cmd_bad, reg_data) :
        status_word;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev_ff <= 1'b0;
            cs_prev_ff <= 1'b1;
        end else begin
            sclk_prev_ff <= sclk_s;
            cs_prev_ff <= cs_s;
        end
    end

    // The bit count saturates so an overlong frame still reads as bad.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_ff <= '0;
            cnt_ff <= '0;
        end else if (cs_fall) begin
            cnt_ff <= '0;
        end else if (sclk_rise) begin
            rx_ff <= {rx_ff[14:0], si_s};
            if (cnt_ff != `SRB_CNT_MAX) begin
                cnt_ff <= cnt_ff + 5'h01;
            end
        end
    end

    // The answer is frozen at frame end, so it reflects status at that time.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_ff <= `SRB_RESET_RESP;
            rst_flag_ff <= 1'b1;
        end else if (frame_end) begin
            resp_ff <= nxt_resp;
            rst_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                regs_ff[i] <= `SRB_DATA_RESET;
            end
        end else if (frame_end && cfg_write) begin
            regs_ff[cmd] <= rx_ff[11:0];
        end
    end

    // Output changes on the falling clock edge for the master to sample.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_ff <= '0;
            spi_so <= 1'b0;
            spi_so_oe <= 1'b0;
        end else if (cs_fall) begin
            spi_so <= resp_ff[15];
            tx_ff <= {resp_ff[14:0], 1'b0};
            spi_so_oe <= 1'b1;
        end else if (frame_end) begin
            spi_so_oe <= 1'b0;
        end else if (sclk_fall) begin
            spi_so <= tx_ff[15];
            tx_ff <= {tx_ff[14:0], 1'b0};
        end
    end

    sequence s_frame_in(logic [3:0] c);
        frame_end && good_len && cmd == c;
    endsequence

    sequence s_read_of(logic [3:0] a);
        s_frame_in(`SRB_CMD_READ) ##0 (rx_ff[11:4] == 8'h00 && addr == a);
    endsequence

    // Assertion helper: data of the last pulse-width write that was taken.
    srb_pkg::srb_data_t pwm_seen_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_seen_ff <= `SRB_DATA_RESET;
        end else if (frame_end && good_len && cmd == `SRB_ADDR_PWM) begin
            pwm_seen_ff <= rx_ff[11:0];
        end
    end

    a_check_signature: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_frame_in(`SRB_CMD_CHECK) |=> resp_ff == `SRB_CHECK_WORD)
        else $error("check signature wrong");
    a_header_supply: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_read_of(`SRB_ADDR_STB_V) |=> resp_ff[13:12]
            == $past({overvoltage, low_voltage}))
        else $error("header supply bits wrong");
    a_range_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        frame_end && !good_len |=> resp_ff[14])
        else $error("range flag missing");
    a_supply_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_read_of(`SRB_ADDR_STATUS) |=> resp_ff[13]
            == $past(overvoltage || low_voltage))
        else $error("supply flag wrong");
    a_nmf_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_read_of(`SRB_ADDR_STATUS) ##0 !v10_en |=> !resp_ff[12])
        else $error("no-max flag without ten-volt mode");
    a_thresh_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_read_of(`SRB_ADDR_STB_V) |=> resp_ff[11:0]
            == $past(regs_ff[`SRB_ADDR_STB_V]))
        else $error("threshold read wrong");
    a_timer_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_read_of(`SRB_ADDR_STB_T) |=> resp_ff[11:0]
            == $past(regs_ff[`SRB_ADDR_STB_T]))
        else $error("timer read wrong");
    a_fault_op_gap: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_read_of(`SRB_ADDR_FAULT_OP) |=> resp_ff[7:4] == 4'h0)
        else $error("fault operation gap not zero");
    a_pwm_last: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_read_of(`SRB_ADDR_PWM) |=> resp_ff[11:0] == $past(pwm_seen_ff))
        else $error("pwm read not last programmed");
    a_rev_word: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_read_of(`SRB_ADDR_REV) |=> resp_ff[11:8] == REVISION_IDENTIFIER
            && resp_ff[1:0] == $past({trim_parity_error, trim_locked_out}))
        else $error("revision word wrong");
    a_ign_masked: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_read_of(`SRB_ADDR_DRV) |=> (resp_ff[7:4] & $past(ign_mode)) == 4'h0)
        else $error("ignition channel shown");
    a_msb_first: assert property (
        @(posedge clk) disable iff (!rst_n)
        cs_fall |=> spi_so_oe && spi_so == $past(resp_ff[15]))
        else $error("first bit not msb");
endmodule : srb_readback
`default_nettype wire

// ### srb_spi_host.sv
`default_nettype none
module srb_spi_host (
    input wire logic clk,
    input wire logic so,
    input wire logic so_oe,
    output var logic sclk,
    output var logic cs_n,
    output var logic si
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_clk

    // Sends one command and returns the answer to the one before it.
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
        xfer_bits(cmd, 16, rsp);
    endtask : xfer

    // A frame cut after n bits leaves the unread answer bits at zero.
    task automatic xfer_bits(input logic [15:0] cmd, input int n,
            output logic [15:0] rsp);
        rsp = '0;
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            si = cmd[i];
            wait_clk(4);
            sclk = 1'b1;
            // A released line must not pass for data, so it reads inverted.
            rsp[i] = so_oe ? so : ~so;
            wait_clk(4);
            sclk = 1'b0;
        end
        wait_clk(4);
        cs_n = 1'b1;
        si = ~si;
        wait_clk(8);
    endtask : xfer_bits
endmodule : srb_spi_host
`default_nettype wire

// ### test_srb_readback.sv
`default_nettype none
module test_srb_readback;
    timeunit 1ns;
    timeprecision 1ps;
    // Arbitrary revision code.
    localparam logic [3:0] REV = 4'h9;
    logic clk, rst_n, sclk, cs_n, si, so, so_oe;
    logic [3:0] ign_f, gp_f, out_f;
    logic ov, lv, cur_max, cur_nom, chi, clo, par, lock;
    int n_errors = 0;
    int check_count = 0;
    logic [15:0] wr_list [7] = '{16'h7055, 16'hbabc, 16'hc123, 16'hd5a5,
                                 16'he1ab, 16'he3c7, 16'h000b};

    srb_readback #(.REVISION_IDENTIFIER(REV)) u_srb_readback (
        .clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_si(si), .spi_so(so), .spi_so_oe(so_oe), .ign_fault(ign_f),
        .gp_fault(gp_f), .out_fault(out_f), .overvoltage(ov),
        .low_voltage(lv), .maximum_current_input(cur_max),
        .nominal_current_input(cur_nom), .calibration_high_flag(chi),
        .calibration_low_flag(clo), .trim_parity_error(par),
        .trim_locked_out(lock));

    srb_spi_host u_srb_spi_host (.clk(clk), .so(so), .so_oe(so_oe),
        .sclk(sclk), .cs_n(cs_n), .si(si));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic run(input logic [15:0] cmd, input logic [15:0] exp);
        logic [15:0] rsp;
        u_srb_spi_host.xfer(cmd, rsp);
        check(rsp, exp);
    endtask : run

    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // A cut frame is refused; the status read after it runs with ten-volt
    // mode still off, so a current fault must not raise the no-max flag.
    task automatic t_cut();
        logic [15:0] rsp;
        u_srb_spi_host.xfer_bits(16'h5580, 8, rsp);
        check(rsp, 16'h0d00);
        cur_max = 1'b1;
        run(16'h0000, 16'h4000);
        cur_max = 1'b0;
        run(16'hf000, 16'h0000);
    endtask : t_cut

    // Every scenario opens by collecting the check word (t_cut only its top byte) and ends on a check.
    task automatic t_regs();
        run(16'h5580, 16'h0d0a);
        foreach (wr_list[i]) run(wr_list[i], 16'h0000);
        run(16'h000c, 16'h0abc);
        run(16'h000d, 16'h0123);
        run(16'h000e, 16'h0505);
        run(16'h0007, 16'h03c7);
        run(16'hf000, 16'h0005);
    endtask : t_regs

    task automatic t_rev();
        {chi, clo, par, lock} = 4'b1001;
        run(16'h000f, 16'h0d0a);
        {chi, clo, par, lock} = 4'b0110;
        run(16'h000f, {4'h0, REV, 4'b0010, 4'b0001});
        run(16'hf000, {4'h0, REV, 4'b0001, 4'b0010});
    endtask : t_rev

    // The second status word shows the supply flag from the low side.
    task automatic t_status();
        {ign_f, gp_f, out_f, ov} = {12'h963, 1'b1};
        run(16'h0010, 16'h0d0a);
        {ov, lv, cur_max} = 3'b011;
        run(16'h0000, 16'h6963);
        run(16'hf000, 16'h3963);
    endtask : t_status

    initial begin
        {rst_n, ign_f, gp_f, out_f, ov, lv} = '0;
        {cur_max, cur_nom, chi, clo, par, lock} = '0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        run(16'hf000, 16'h8000);
        t_cut();
        t_regs();
        t_rev();
        t_status();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
endmodule : test_srb_readback
`default_nettype wire
